// ==== design/crc_scan_top.v ====
`default_nettype none

module crc_scan_top (
	// Clock and reset
	input wire ref_clk_i,
	input wire reset_n_i,
	// Register port
	input wire [4:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Program memory read port
	output reg [15:0] mem_addr_o,
	output reg mem_rd_o,
	input wire [15:0] mem_data_i,
	input wire mem_impl_i,
	input wire mem_free_i,
	// CPU interaction
	input wire irq_active_i,
	output reg cpu_stall_o,
	// Trigger sources, code order
	input wire [9:0] trig_src_i,
	// Interrupt requests
	output reg crc_irq_o,
	output reg scan_irq_o
);
`include "crc_scan_regs.vh"

	localparam S_IDLE = 2'h0;
	localparam S_WAIT = 2'h1;
	localparam S_READ = 2'h2;
	localparam S_LOAD = 2'h3;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [15:0] acc_q;
	reg [15:0] poly_q;
	reg [15:0] dat_q;
	reg [15:0] shift_q;
	reg [4:0] cnt_q;
	reg crc_en_q;
	reg crc_go_q;
	reg augment_zeros_bit_q;
	reg shift_direction_bit_q;
	reg full_q;
	reg [3:0] data_length_field_q;
	reg [3:0] polynomial_length_field_q;
	reg busy_q;
	reg crc_done_q;
	reg crc_ie_q;
	reg scan_en_q;
	reg scan_go_q;
	reg scan_go_prev_q;
	reg scan_interrupt_mode_q;
	reg invalid_q;
	reg [1:0] mode_q;
	reg [15:0] start_q;
	reg [15:0] end_q;
	reg [3:0] trigger_source_field_q;
	reg scan_done_q;
	reg scan_ie_q;
	reg [1:0] state_q;
	reg trig_pend_q;
	reg [7:0] rdata_d;

	wire [15:0] acc_next;
	wire [9:0] trig_rise;
	wire [15:0] trig_vec = {6'h00, trig_rise};
	wire trig_hit = trig_vec[trigger_source_field_q];
	wire crc_run = crc_en_q & crc_go_q;
	wire shifting = (cnt_q != `CNT_ZERO);
	wire crc_busy_now = crc_run & (full_q | shifting);
	wire crc_ready = crc_run & ~full_q;
	wire load_word = crc_run & full_q & ~shifting;
	wire din = shift_direction_bit_q ? shift_q[0] : shift_q[data_length_field_q];
	wire mem_bad = scan_en_q & scan_go_q & (state_q == S_LOAD) & ~mem_impl_i;
	wire sw_wr = reg_wr_i;
	wire int_hold = scan_interrupt_mode_q & irq_active_i;
	wire mode_ok = (mode_q == `MODE_PEEK) ? mem_free_i :
		(mode_q == `MODE_TRIGGERED) ? trig_pend_q : 1'b1;
	wire may_fetch = crc_ready & ~int_hold & mode_ok;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	crc_step u_step (
		.acc_i(acc_q),
		.poly_i(poly_q),
		.din_i(din),
		.polynomial_length_field_i(polynomial_length_field_q),
		.augment_i(augment_zeros_bit_q),
		.acc_o(acc_next)
	);

	trig_sync u_trig (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.raw_i(trig_src_i),
		.rise_o(trig_rise)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rdata_d = `RST_BYTE;
		if (reg_addr_i == `A_ACC_LO) begin
			rdata_d = acc_q[7:0];
		end else if (reg_addr_i == `A_ACC_HI) begin
			rdata_d = acc_q[15:8];
		end else if (reg_addr_i == `A_POLY_LO) begin
			rdata_d = {poly_q[7:1], 1'b0};
		end else if (reg_addr_i == `A_POLY_HI) begin
			rdata_d = poly_q[15:8];
		end else if (reg_addr_i == `A_DAT_LO) begin
			rdata_d = dat_q[7:0];
		end else if (reg_addr_i == `A_DAT_HI) begin
			rdata_d = dat_q[15:8];
		end else if (reg_addr_i == `A_SHIFT_LO) begin
			rdata_d = shift_q[7:0];
		end else if (reg_addr_i == `A_SHIFT_HI) begin
			rdata_d = shift_q[15:8];
		end else if (reg_addr_i == `A_CRC_CTRL) begin
			rdata_d[`B_EN] = crc_en_q;
			rdata_d[`B_GO] = crc_go_q;
			rdata_d[`B_BUSY] = busy_q;
			rdata_d[`B_AUGMENT_ZEROS_BIT] = augment_zeros_bit_q;
			rdata_d[`B_SHIFT_DIRECTION_BIT] = shift_direction_bit_q;
			rdata_d[`B_FULL] = full_q;
		end else if (reg_addr_i == `A_CRC_LEN) begin
			rdata_d = {data_length_field_q, polynomial_length_field_q};
		end else if (reg_addr_i == `A_SCAN_CTRL) begin
			rdata_d[`B_EN] = scan_en_q;
			rdata_d[`B_GO] = scan_go_q;
			rdata_d[`B_BUSY] = (state_q != S_IDLE);
			rdata_d[`B_INVALID] = invalid_q;
			rdata_d[`B_SCAN_INTERRUPT_MODE] = scan_interrupt_mode_q;
			rdata_d[1:0] = mode_q;
		end else if (reg_addr_i == `A_START_LO) begin
			rdata_d = start_q[7:0];
		end else if (reg_addr_i == `A_START_HI) begin
			rdata_d = start_q[15:8];
		end else if (reg_addr_i == `A_END_LO) begin
			rdata_d = end_q[7:0];
		end else if (reg_addr_i == `A_END_HI) begin
			rdata_d = end_q[15:8];
		end else if (reg_addr_i == `A_TRIG_SEL) begin
			rdata_d[3:0] = trigger_source_field_q;
		end else if (reg_addr_i == `A_FLAGS) begin
			// Engine-done and scan-done flags; the scan flag also sets on an invalid abort or a stop
			rdata_d[`B_CRC_FLAG] = crc_done_q;
			rdata_d[`B_SCAN_FLAG] = scan_done_q;
		end else if (reg_addr_i == `A_IRQ_EN) begin
			rdata_d[`B_CRC_FLAG] = crc_ie_q;
			rdata_d[`B_SCAN_FLAG] = scan_ie_q;
		end
	end

	// ----------------------------------------
	// Engine, scanner and registers
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc_q <= `RST_WORD;
			poly_q <= `RST_WORD;
			dat_q <= `RST_WORD;
			shift_q <= `RST_WORD;
			cnt_q <= `CNT_ZERO;
			crc_en_q <= 1'b0;
			crc_go_q <= 1'b0;
			augment_zeros_bit_q <= 1'b0;
			shift_direction_bit_q <= 1'b0;
			full_q <= 1'b0;
			data_length_field_q <= `RST_NIB;
			polynomial_length_field_q <= `RST_NIB;
			busy_q <= 1'b0;
			crc_done_q <= 1'b0;
			crc_ie_q <= 1'b0;
			scan_en_q <= 1'b0;
			scan_go_q <= 1'b0;
			scan_go_prev_q <= 1'b0;
			scan_interrupt_mode_q <= 1'b0;
			invalid_q <= 1'b0;
			mode_q <= `RST_MODE;
			start_q <= `RST_WORD;
			end_q <= `RST_WORD;
			trigger_source_field_q <= `RST_NIB;
			scan_done_q <= 1'b0;
			scan_ie_q <= 1'b0;
			state_q <= S_IDLE;
			trig_pend_q <= 1'b0;
			mem_addr_o <= `RST_WORD;
			mem_rd_o <= 1'b0;
			cpu_stall_o <= 1'b0;
			crc_irq_o <= 1'b0;
			scan_irq_o <= 1'b0;
			reg_rdata_o <= `RST_BYTE;
		end else begin
			reg_rdata_o <= reg_rd_i ? rdata_d : `RST_BYTE;

			// Shifter: take a pending word, then one bit per clock
			if (load_word) begin
				shift_q <= dat_q;
				cnt_q <= {1'b0, data_length_field_q} + `CNT_ONE;
				full_q <= 1'b0;
			end else if (shifting) begin
				acc_q <= acc_next;
				cnt_q <= cnt_q - `CNT_ONE;
				if (shift_direction_bit_q) begin
					shift_q <= {1'b0, shift_q[15:1]};
				end else begin
					shift_q <= {shift_q[14:0], 1'b0};
				end
			end
			busy_q <= crc_busy_now;

			// Scanner sequencing
			if (!scan_en_q) begin
				state_q <= S_IDLE;
				mem_rd_o <= 1'b0;
				trig_pend_q <= 1'b0;
			end else begin
				if (trig_hit && (mode_q == `MODE_TRIGGERED)) begin
					trig_pend_q <= 1'b1;
				end
				case (state_q)
					S_IDLE: begin
						trig_pend_q <= 1'b0;
						if (scan_go_q) begin
							mem_addr_o <= start_q;
							state_q <= S_WAIT;
						end
					end
					S_WAIT: begin
						if (!scan_go_q) begin
							state_q <= S_IDLE;
						end else if (may_fetch) begin
							// Waits for running, empty engine
							mem_rd_o <= 1'b1;
							state_q <= S_READ;
							if (!trig_hit) begin
								trig_pend_q <= 1'b0;
							end
						end
					end
					S_READ: begin
						mem_rd_o <= 1'b0;
						state_q <= scan_go_q ? S_LOAD : S_IDLE;
					end
					S_LOAD: begin
						if (!scan_go_q) begin
							state_q <= S_IDLE;
						end else if (!mem_impl_i) begin
							invalid_q <= 1'b1;
							scan_go_q <= 1'b0;
							state_q <= S_IDLE;
						end else begin
							dat_q <= mem_data_i;
							full_q <= 1'b1;
							if (mem_addr_o == end_q) begin
								scan_go_q <= 1'b0;
								state_q <= S_IDLE;
							end else begin
								mem_addr_o <= mem_addr_o + `ADDR_ONE;
								state_q <= S_WAIT;
							end
						end
					end
					default: begin
						state_q <= S_IDLE;
					end
				endcase
			end
			cpu_stall_o <= scan_en_q & (((mode_q == `MODE_BURST) && (state_q != S_IDLE)) ||
				((mode_q == `MODE_CONCURRENT) && (state_q == S_READ)));

			// Register writes
			if (sw_wr) begin
				if (reg_addr_i == `A_ACC_LO) begin
					acc_q[7:0] <= reg_wdata_i;
				end else if (reg_addr_i == `A_ACC_HI) begin
					acc_q[15:8] <= reg_wdata_i;
				end else if (reg_addr_i == `A_POLY_LO) begin
					poly_q[7:0] <= {reg_wdata_i[7:1], 1'b0};
				end else if (reg_addr_i == `A_POLY_HI) begin
					poly_q[15:8] <= reg_wdata_i;
				end else if (reg_addr_i == `A_DAT_LO && state_q != S_LOAD) begin
					dat_q[7:0] <= reg_wdata_i;
					full_q <= 1'b1;
				end else if (reg_addr_i == `A_DAT_HI && state_q != S_LOAD) begin
					dat_q[15:8] <= reg_wdata_i;
				end else if (reg_addr_i == `A_CRC_CTRL) begin
					crc_en_q <= reg_wdata_i[`B_EN];
					crc_go_q <= reg_wdata_i[`B_GO];
					augment_zeros_bit_q <= reg_wdata_i[`B_AUGMENT_ZEROS_BIT];
					shift_direction_bit_q <= reg_wdata_i[`B_SHIFT_DIRECTION_BIT];
				end else if (reg_addr_i == `A_CRC_LEN) begin
					data_length_field_q <= reg_wdata_i[7:4];
					polynomial_length_field_q <= reg_wdata_i[3:0];
				end else if (reg_addr_i == `A_SCAN_CTRL) begin
					scan_en_q <= reg_wdata_i[`B_EN];
					scan_go_q <= reg_wdata_i[`B_GO];
					invalid_q <= (invalid_q & reg_wdata_i[`B_INVALID]) | mem_bad;
					scan_interrupt_mode_q <= reg_wdata_i[`B_SCAN_INTERRUPT_MODE];
					mode_q <= reg_wdata_i[1:0];
				end else if (reg_addr_i == `A_START_LO) begin
					start_q[7:0] <= reg_wdata_i;
				end else if (reg_addr_i == `A_START_HI) begin
					start_q[15:8] <= reg_wdata_i;
				end else if (reg_addr_i == `A_END_LO) begin
					end_q[7:0] <= reg_wdata_i;
				end else if (reg_addr_i == `A_END_HI) begin
					end_q[15:8] <= reg_wdata_i;
				end else if (reg_addr_i == `A_TRIG_SEL) begin
					trigger_source_field_q <= reg_wdata_i[3:0];
				end else if (reg_addr_i == `A_IRQ_EN) begin
					crc_ie_q <= reg_wdata_i[`B_CRC_FLAG];
					scan_ie_q <= reg_wdata_i[`B_SCAN_FLAG];
				end
			end

			// Flags: write one clears, a new event wins
			scan_go_prev_q <= scan_go_q;
			if (busy_q && !crc_busy_now) begin
				crc_done_q <= 1'b1;
			end else if (sw_wr && reg_addr_i == `A_FLAGS && reg_wdata_i[`B_CRC_FLAG]) begin
				crc_done_q <= 1'b0;
			end
			if (scan_go_prev_q && !scan_go_q) begin
				scan_done_q <= 1'b1;
			end else if (sw_wr && reg_addr_i == `A_FLAGS && reg_wdata_i[`B_SCAN_FLAG]) begin
				scan_done_q <= 1'b0;
			end
			crc_irq_o <= crc_done_q & crc_ie_q;
			scan_irq_o <= scan_done_q & scan_ie_q;
		end
	end

endmodule // crc_scan_top

`default_nettype wire

// ==== design/crc_step.v ====
`default_nettype none

// ----------------------------------------
// One shift of the accumulator
// ----------------------------------------
module crc_step (
	// Operands
	input wire [15:0] acc_i,
	input wire [15:0] poly_i,
	input wire din_i,
	input wire [3:0] polynomial_length_field_i,
	input wire augment_i,
	// Result
	output reg [15:0] acc_o
);
`include "crc_scan_regs.vh"

	function [3:0] top_bit;
		input [3:0] polynomial_length_field;
		reg [4:0] t;
		begin
			t = {1'b0, polynomial_length_field} + `CNT_ONE;
			if (t > `TOP_CLAMP) begin
				t = `TOP_CLAMP;
			end
			top_bit = t[3:0];
		end
	endfunction

	reg [15:0] mask;
	reg [15:0] shifted;
	reg fb;
	integer i;

	always @* begin
		mask = `RST_WORD;
		for (i = 0; i < 16; i = i + 1) begin
			mask[i] = (i <= top_bit(polynomial_length_field_i));
		end
		// Width follows polynomial length
		fb = acc_i[top_bit(polynomial_length_field_i)] ^ (augment_i & din_i);
		shifted = {acc_i[14:0], augment_i ? 1'b0 : din_i};
		// Polynomial low bit is implied one
		acc_o = (shifted ^ (fb ? {poly_i[15:1], 1'b1} : `RST_WORD)) & mask;
	end

endmodule // crc_step

`default_nettype wire

// ==== design/trig_sync.v ====
`default_nettype none

// ----------------------------------------
// Trigger input synchroniser and edge finder
// ----------------------------------------
module trig_sync (
	// Clock and reset
	input wire ref_clk_i,
	input wire reset_n_i,
	// Raw and edge
	input wire [9:0] raw_i,
	output reg [9:0] rise_o
);
`include "crc_scan_regs.vh"

	reg [9:0] s1_q;
	reg [9:0] s2_q;
	reg [9:0] s3_q;
	reg [9:0] stable_q;

	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= 10'h000;
			s2_q <= 10'h000;
			s3_q <= 10'h000;
			stable_q <= 10'h000;
			rise_o <= 10'h000;
		end else begin
			s1_q <= raw_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Level taken only once second and third agree
			stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
			rise_o <= (s2_q & s3_q) & ~stable_q;
		end
	end

endmodule // trig_sync

`default_nettype wire

// ==== include/crc_scan_regs.vh ====
`ifndef CRC_SCAN_REGS_VH
`define CRC_SCAN_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define A_ACC_LO 5'h00
`define A_ACC_HI 5'h01
`define A_POLY_LO 5'h02
`define A_POLY_HI 5'h03
`define A_DAT_LO 5'h04
`define A_DAT_HI 5'h05
`define A_SHIFT_LO 5'h06
`define A_SHIFT_HI 5'h07
`define A_CRC_CTRL 5'h08
`define A_CRC_LEN 5'h09
`define A_SCAN_CTRL 5'h0A
`define A_START_LO 5'h0B
`define A_START_HI 5'h0C
`define A_END_LO 5'h0D
`define A_END_HI 5'h0E
`define A_TRIG_SEL 5'h0F
`define A_FLAGS 5'h10
`define A_IRQ_EN 5'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_EN 7
`define B_GO 6
`define B_BUSY 5
`define B_AUGMENT_ZEROS_BIT 4
`define B_INVALID 4
`define B_SCAN_INTERRUPT_MODE 3
`define B_SHIFT_DIRECTION_BIT 1
`define B_FULL 0
`define B_CRC_FLAG 0
`define B_SCAN_FLAG 1

// ----------------------------------------
// Access modes and trigger select
// ----------------------------------------
`define MODE_CONCURRENT 2'h0
`define MODE_BURST 2'h1
`define MODE_PEEK 2'h2
`define MODE_TRIGGERED 2'h3
`define TRIG_SOURCES 10

// ----------------------------------------
// Reset values and small constants
// ----------------------------------------
`define RST_WORD 16'h0000
`define RST_NIB 4'h0
`define RST_MODE 2'h0
`define RST_BYTE 8'h00
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define ADDR_ONE 16'h0001
`define TOP_CLAMP 5'h0F

`endif

// ==== verification/crc_scan_props.sv ====
`default_nettype none
module crc_scan_props (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Memory and requests
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_rd_o,
	input wire logic cpu_stall_o,
	input wire logic crc_irq_o,
	input wire logic scan_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Address of the previous fetch
	logic [15:0] last_addr_q;
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last_addr_q <= 16'h0000;
		end else if (mem_rd_o) begin
			last_addr_q <= mem_addr_o;
		end
	end
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence rd_then_idle;
		reg_rd_i ##1 !reg_rd_i;
	endsequence
	sequence fetch_pair;
		mem_rd_o ##1 !mem_rd_o [*3] ##[1:32] mem_rd_o;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	chk_rdata_cause: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
		else $error("read data outside its cycle");
	chk_rdata_drop: assert property (rd_then_idle |=> reg_rdata_o == 8'h00)
		else $error("read data held too long");
	chk_fetch_gap: assert property (mem_rd_o |=> !mem_rd_o [*2])
		else $error("fetches too close");
	chk_fetch_step: assert property (fetch_pair |-> mem_addr_o == last_addr_q + 16'h0001)
		else $error("scan address not stepped by one");
	chk_addr_hold: assert property (mem_rd_o |=> $stable(mem_addr_o))
		else $error("address moved in data cycle");
	chk_crc_irq_clr: assert property ($fell(crc_irq_o) |-> $past(reg_wr_i, 2))
		else $error("done request dropped without write");
	chk_scan_irq_clr: assert property ($fell(scan_irq_o) |-> $past(reg_wr_i, 2))
		else $error("scan request dropped without write");
	chk_reset_quiet: assert property ($rose(reset_n_i) |-> !(mem_rd_o || cpu_stall_o || crc_irq_o || scan_irq_o))
		else $error("outputs active after reset");
endmodule // crc_scan_props
`default_nettype wire

// ==== verification/crc_scan_tb.sv ====
`default_nettype none
`include "crc_scan_regs.vh"
module crc_scan_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic mem_free_i = 1'h0;
	logic irq_active_i = 1'h0;
	logic [4:0] reg_addr_i = 5'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [11:0] tcnt = 12'h000;
	logic [7:0] reg_rdata_o, d;
	logic [15:0] mem_addr_o, mem_data_i;
	logic mem_rd_o, mem_impl_i, cpu_stall_o, crc_irq_o, scan_irq_o;
	int reads, cyc = 0, bad_count = 0, compares = 0;

	always #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		tcnt <= tcnt + 12'h001;
		mem_free_i <= ~mem_free_i;
		cyc++;
		if (cyc > 60000) begin
			bad_count++;
			give_verdict();
		end
	end

	crc_scan_top u_crc_scan_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .mem_impl_i(mem_impl_i),
		.mem_free_i(mem_free_i), .irq_active_i(irq_active_i), .cpu_stall_o(cpu_stall_o),
		.trig_src_i(tcnt[11:2]), .crc_irq_o(crc_irq_o), .scan_irq_o(scan_irq_o));
	mem_model u_mem_model (.clk_i(ref_clk_i), .rst_n_i(reset_n_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
		.data_o(mem_data_i), .impl_o(mem_impl_i), .reads_o(reads));

	task automatic give_verdict;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'h1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h0;
		@(posedge ref_clk_i);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h0;
		#1 q = reg_rdata_o;
		@(posedge ref_clk_i);
	endtask
	task automatic poll(input logic [4:0] a, input int b, input logic v);
		for (int i = 0; i < 3000; i++) begin
			rd(a, d);
			if (d[b] === v)
				return;
		end
		chk(d[b], v, "wait expired");
	endtask
	// Bit-serial reference of the engine
	function automatic logic [15:0] crc_ref(input logic [15:0] acc, input logic [15:0] poly,
		input logic [15:0] dat, input int dl, input int pl, input logic aug, input logic lsb);
		logic [15:0] m;
		logic b;
		logic fb;
		m = 16'hFFFF >> (14 - pl);
		acc = acc & m;
		for (int i = 0; i <= dl; i++) begin
			b = lsb ? dat[i] : dat[dl - i];
			fb = acc[pl + 1];
			acc = aug ? acc << 1 : {acc[14:0], b};
			if (aug ? fb ^ b : fb)
				acc = acc ^ (poly | 16'h0001);
			acc = acc & m;
		end
		return acc;
	endfunction

	task automatic run_regs;
		for (int a = 0; a < 32; a++) begin
			rd(5'(a), d);
			chk(d, 8'h00, "reset value");
		end
		wr(`A_TRIG_SEL, 8'hFF);
		rd(`A_TRIG_SEL, d);
		chk(d, 8'h0F, "trigger select");
		wr(`A_SCAN_CTRL, 8'h3F);
		rd(`A_SCAN_CTRL, d);
		chk(d, 8'h0B, "scan control bits");
		wr(`A_SCAN_CTRL, 8'h00);
		wr(5'h1F, 8'hFF);
		rd(5'h1F, d);
		chk(d, 8'h00, "unmapped");
	endtask
	task automatic run_manual;
		logic [15:0] x;
		logic [7:0] c;
		wr(`A_IRQ_EN, 8'h03);
		for (int k = 0; k < 4; k++) begin
			c = {3'h6, k[0], 2'h0, k[1], 1'h0};
			wr(`A_CRC_CTRL, 8'h00);
			wr(`A_ACC_LO, 8'h5A);
			wr(`A_ACC_HI, 8'h00);
			wr(`A_POLY_LO, 8'h07);
			wr(`A_POLY_HI, 8'h00);
			wr(`A_CRC_LEN, 8'h76);
			wr(`A_CRC_CTRL, c);
			rd(`A_CRC_CTRL, d);
			chk(d & 8'hDE, c, "control readback");
			wr(`A_DAT_HI, 8'hE7);
			wr(`A_DAT_LO, 8'h31);
			poll(`A_CRC_CTRL, 0, 1'h0);
			wr(`A_DAT_LO, 8'hC4);
			poll(`A_CRC_CTRL, 5, 1'h0);
			x = crc_ref(16'h005A, 16'h0007, 16'h0031, 7, 6, k[0], k[1]);
			x = crc_ref(x, 16'h0007, 16'h00C4, 7, 6, k[0], k[1]);
			rd(`A_ACC_LO, d);
			chk(d, x[7:0], "manual result");
			chk(crc_irq_o, 1'h1, "done request");
			wr(`A_FLAGS, 8'h01);
			rd(`A_FLAGS, d);
			chk({crc_irq_o, d}, 9'h000, "done cleared");
		end
	endtask
	task automatic run_scan(input logic [1:0] md, input logic [3:0] ts, input logic [15:0] s,
		input logic [15:0] e, input logic hold);
		logic [15:0] x;
		logic [15:0] top;
		int n;
		wr(`A_CRC_CTRL, 8'h00);
		wr(`A_ACC_LO, 8'hFF);
		wr(`A_ACC_HI, 8'hFF);
		wr(`A_POLY_LO, 8'h21);
		wr(`A_POLY_HI, 8'h10);
		wr(`A_CRC_LEN, 8'hFE);
		wr(`A_CRC_CTRL, 8'hD0);
		wr(`A_START_LO, s[7:0]);
		wr(`A_START_HI, s[15:8]);
		wr(`A_END_LO, e[7:0]);
		wr(`A_END_HI, e[15:8]);
		wr(`A_TRIG_SEL, {4'h0, ts});
		n = reads;
		irq_active_i <= hold;
		wr(`A_SCAN_CTRL, {4'hC, hold, 1'h0, md});
		if (hold || ts > 4'h9) begin
			repeat (300) @(posedge ref_clk_i);
			chk(16'(reads - n), 16'h0000, "fetch while held");
			irq_active_i <= 1'h0;
			wr(`A_TRIG_SEL, 8'h02);
		end
		poll(`A_SCAN_CTRL, 6, 1'h0);
		poll(`A_CRC_CTRL, 5, 1'h0);
		top = e < 16'h0100 ? e : 16'h00FF;
		x = 16'hFFFF;
		for (logic [15:0] a = s; a <= top; a++)
			x = crc_ref(x, 16'h1021, a ^ 16'h5A3C, 15, 14, 1'h1, 1'h0);
		rd(`A_ACC_LO, d);
		chk(d, x[7:0], "scan result low");
		rd(`A_ACC_HI, d);
		chk(d, x[15:8], "scan result high");
		chk(16'(reads - n), top - s + 16'h0001 + {15'h0, e > top}, "fetch count");
		rd(`A_FLAGS, d);
		chk({scan_irq_o, d}, 9'h103, "flags after scan");
		rd(`A_SCAN_CTRL, d);
		chk(d[4], e > top, "invalid bit");
		wr(`A_FLAGS, 8'h03);
	endtask
	task automatic run_stop;
		int n;
		wr(`A_CRC_CTRL, 8'hD0);
		wr(`A_START_LO, 8'h20);
		wr(`A_END_LO, 8'hFF);
		wr(`A_END_HI, 8'h00);
		wr(`A_SCAN_CTRL, 8'hC1);
		repeat (30) @(posedge ref_clk_i);
		chk(cpu_stall_o, 1'h1, "stall in burst");
		wr(`A_SCAN_CTRL, 8'h81);
		@(posedge ref_clk_i);
		n = reads;
		repeat (40) @(posedge ref_clk_i);
		chk(16'(reads - n), 16'h0000, "fetch after stop");
		chk(cpu_stall_o, 1'h0, "stall after stop");
		rd(`A_FLAGS, d);
		chk(d[1], 1'h1, "flag on stop");
		wr(`A_SCAN_CTRL, 8'h00);
		rd(`A_START_LO, d);
		chk(d, 8'h20, "start kept");
	endtask

	initial begin
		repeat (20) @(posedge ref_clk_i);
		reset_n_i <= 1'h1;
		@(posedge ref_clk_i);
		run_regs();
		run_manual();
		run_scan(`MODE_BURST, 4'h0, 16'h0010, 16'h0013, 1'h0);
		run_scan(`MODE_PEEK, 4'h0, 16'h0020, 16'h0022, 1'h0);
		run_scan(`MODE_CONCURRENT, 4'h0, 16'h0030, 16'h0031, 1'h1);
		run_scan(`MODE_CONCURRENT, 4'h0, 16'h00FE, 16'h0105, 1'h0);
		for (int t = 0; t < 16; t++)
			run_scan(`MODE_TRIGGERED, 4'(t), 16'h0050, 16'h0050, 1'h0);
		run_stop();
		give_verdict();
	end
endmodule // crc_scan_tb

bind crc_scan_top crc_scan_props u_crc_scan_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o),
	.mem_rd_o(mem_rd_o), .cpu_stall_o(cpu_stall_o), .crc_irq_o(crc_irq_o), .scan_irq_o(scan_irq_o));
`default_nettype wire

// ==== verification/mem_model.sv ====
`default_nettype none
module mem_model #(
	parameter logic [15:0] IMPL_TOP = 16'h0100
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] addr_i,
	input wire logic rd_i,
	output logic [15:0] data_o,
	output logic impl_o,
	output int reads_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Answer one cycle after a request, scramble otherwise
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_o <= 16'h0000;
			impl_o <= 1'h0;
			reads_o <= 0;
		end else if (rd_i) begin
			data_o <= addr_i ^ 16'h5A3C;
			impl_o <= addr_i < IMPL_TOP;
			reads_o <= reads_o + 1;
		end else begin
			data_o <= ~data_o;
			impl_o <= ~impl_o;
		end
	end
endmodule // mem_model
`default_nettype wire
